// ===== da_fir_filter.sv
`timescale 1ns/1ps
`include "fir_regs.svh"
module da_fir_filter #(
    parameter int NUM_TAPS = `FIR_DEF_TAPS,
    parameter int DATA_W = `FIR_DEF_DATA_W,
    parameter int COEF_W = `FIR_DEF_COEF_W,
    parameter int COEF_FRAC = `FIR_DEF_COEF_FRAC,
    parameter int NUM_CH = 1,
    parameter bit SERIAL_IN = 1'b1,
    parameter fir_pkg::rate_mode_t RATE = fir_pkg::RATE_SINGLE,
    parameter int FACTOR = `FIR_DEF_FACTOR,
    parameter fir_pkg::tap_struct_t TAP_STRUCT = fir_pkg::STRUCT_NONE,
    parameter logic [NUM_TAPS-1:0][COEF_W-1:0] COEF_INIT = '0,
    parameter int FIFO_DEPTH = `FIR_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    fir_link_if.device link
);
    localparam int OUT_W = DATA_W + COEF_W + $clog2(NUM_TAPS);
    localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
    localparam int IDX_W = $clog2(NUM_TAPS);
    localparam int PH_W = (FACTOR > 1) ? $clog2(FACTOR) : 1;
    localparam int HALF = NUM_TAPS / 2;
    localparam int CENTER = (NUM_TAPS - 1) / 2;
    // several channels leave no room for a polyphase schedule
    localparam fir_pkg::rate_mode_t EFF_RATE = (NUM_CH > 1) ? fir_pkg::RATE_SINGLE : RATE;
    localparam bit FOLDED = (TAP_STRUCT == fir_pkg::STRUCT_SYM) || (TAP_STRUCT == fir_pkg::STRUCT_NEGSYM)
        || (TAP_STRUCT == fir_pkg::STRUCT_HALFBAND);
    localparam logic [15:0] REBUILD_CYCLES = 16'(NUM_TAPS + (FOLDED ? HALF : 0) + `FIR_REBUILD_BASE);

    typedef struct packed {
        fir_pkg::reload_state_t mode;
        logic [IDX_W-1:0] idx;
        logic [15:0] rebuild;
        logic [CH_W-1:0] ch;
        logic [PH_W-1:0] phase;
        logic vHold;
        logic [NUM_CH-1:0][DATA_W-1:0] hold;
        logic [NUM_CH-1:0][NUM_TAPS-1:0][DATA_W-1:0] line;
        logic [NUM_TAPS-1:0][COEF_W-1:0] coef;
    } state_t;
    state_t st, next_st;

    logic fifoInReady;
    logic produce;
    logic signed [OUT_W-1:0] acc;
    logic [CH_W+OUT_W-1:0] fifoOut;

    // folded structures only trust the first half of the stored taps
    function automatic logic signed [COEF_W-1:0] effCoef(
        input logic [NUM_TAPS-1:0][COEF_W-1:0] c,
        input int i
    );
        int j;
        logic signed [COEF_W-1:0] v;
        j = (FOLDED && i >= NUM_TAPS - HALF) ? NUM_TAPS - 1 - i : i;
        v = c[j];
        case (TAP_STRUCT)
            fir_pkg::STRUCT_NEGSYM: begin
                if (j != i) begin
                    v = -v;
                end
            end
            fir_pkg::STRUCT_HALFBAND: begin
                if (i != CENTER && ((i - CENTER) % 2) == 0) begin
                    v = '0;
                end
            end
            default: begin
            end
        endcase
        return v;
    endfunction : effCoef

    function automatic logic [PH_W-1:0] nextPhase(input logic [PH_W-1:0] p);
        return (p == PH_W'(FACTOR - 1)) ? '0 : p + 1'b1;
    endfunction : nextPhase

    function automatic logic [CH_W-1:0] nextChannel(input logic [CH_W-1:0] c);
        return (c == CH_W'(NUM_CH - 1)) ? '0 : c + 1'b1;
    endfunction : nextChannel

    // full precision sum, so no tap product can overflow the result word
    function automatic logic signed [OUT_W-1:0] firSum(
        input logic [NUM_TAPS-1:0][COEF_W-1:0] c,
        input logic [NUM_TAPS-1:0][DATA_W-1:0] t
    );
        logic signed [OUT_W-1:0] s;
        s = '0;
        for (int i = 0; i < NUM_TAPS; i++) begin
            s = s + OUT_W'(effCoef(c, i) * $signed(t[i]));
        end
        return s;
    endfunction : firSum

    always_comb begin
        logic step;
        logic xValid;
        logic [DATA_W-1:0] x;
        logic [NUM_TAPS-1:0][DATA_W-1:0] taps;
        step = 1'b0;
        xValid = 1'b0;
        x = '0;
        taps = '0;
        acc = '0;
        produce = 1'b0;
        next_st = st;
        // rfd kept in every configuration; an unused one costs one gate
        // sample period of one input lasts FACTOR cycles when interpolating
        link.rfd = (st.mode == fir_pkg::ST_RUN) && fifoInReady
            && (EFF_RATE != fir_pkg::RATE_INTERP || st.phase == '0);
        link.selIn = st.ch;
        step = (st.mode == fir_pkg::ST_RUN) && fifoInReady;
        if (step) begin
            if (EFF_RATE == fir_pkg::RATE_INTERP && st.phase != '0) begin
                x = '0;
                xValid = st.vHold;
            end else begin
                if (SERIAL_IN || NUM_CH == 1) begin
                    x = link.sampleIn;
                end else if (st.ch == '0) begin
                    x = link.sampleInPar[0];
                    next_st.hold = link.sampleInPar;
                end else begin
                    x = st.hold[st.ch];
                end
                xValid = link.vin;
                next_st.vHold = link.vin;
            end
            taps = {st.line[st.ch][NUM_TAPS-2:0], x};
            acc = firSum(st.coef, taps);
            if (xValid) begin
                next_st.line[st.ch] = taps;
            end
            case (EFF_RATE)
                fir_pkg::RATE_DECIM: produce = xValid && st.phase == PH_W'(FACTOR - 1);
                default: produce = xValid;
            endcase
            if (EFF_RATE != fir_pkg::RATE_SINGLE) begin
                next_st.phase = nextPhase(st.phase);
            end
            if (NUM_CH > 1) begin
                next_st.ch = nextChannel(st.ch);
            end
        end
        // a fresh request wins over a write in the same cycle
        if (link.load) begin
            next_st.mode = fir_pkg::ST_RELOAD;
            next_st.idx = '0;
            next_st.rebuild = '0;
        end else begin
            case (st.mode)
                fir_pkg::ST_RELOAD: begin
                    // words written before a restart stay until overwritten
                    if (link.coefWe) begin
                        next_st.coef[st.idx] = link.coef;
                        next_st.idx = st.idx + 1'b1;
                        if (st.idx == IDX_W'(NUM_TAPS - 1)) begin
                            next_st.mode = fir_pkg::ST_REBUILD;
                            next_st.rebuild = REBUILD_CYCLES;
                        end
                    end
                end
                fir_pkg::ST_REBUILD: begin
                    // new words are live at once; this only holds samples off
                    if (st.rebuild <= 16'h0001) begin
                        next_st.mode = fir_pkg::ST_RUN;
                    end else begin
                        next_st.rebuild = st.rebuild - 16'h0001;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // results wait here so a slow consumer stalls the filter instead of losing data
    fir_fifo #(
        .WIDTH(CH_W + OUT_W),
        .DEPTH(FIFO_DEPTH)
    ) resultFifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .inValid(produce),
        .inReady(fifoInReady),
        .inData({st.ch, acc}),
        .outValid(link.vout),
        .outReady(link.outReady),
        .outData(fifoOut)
    );

    // channel rides in the top bits of each stored word
    assign link.sampleOut = fifoOut[OUT_W-1:0];
    assign link.selOut = fifoOut[CH_W+OUT_W-1:OUT_W];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.mode <= fir_pkg::ST_RUN;
            st.coef <= COEF_INIT;
            st.phase <= PH_W'(`FIR_RESET_PHASE);
        end else begin
            st <= next_st;
        end
    end
endmodule : da_fir_filter

// ===== da_fir_filter_reload_test.sv
`timescale 1ns/1ps
`include "fir_regs.svh"
module da_fir_filter_reload_test;
    localparam int TAPS = 4;
    localparam int DW = 8;
    localparam int CW = 8;
    localparam int OW = DW + CW + 2;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic [DW-1:0] userSample = '0;
    logic [DW-1:0] userSamplePar = '0;
    logic userValid = 1'h0;
    logic userLoadReq = 1'h0;
    logic [CW-1:0] userCoef = '0;
    logic userCoefWe = 1'h0;
    logic resReady = 1'h0;
    logic userReady;
    logic [0:0] userChannel;
    logic [OW-1:0] resSample;
    logic [0:0] resChannel;
    logic resValid;
    int errTotal = 0;
    int testsRun = 0;
    int cycles = 0;
    logic [15:0] lfsrState = 16'h000E;
    logic signed [CW-1:0] coefModel [TAPS] = '{default: '0};
    logic signed [DW-1:0] histModel [TAPS] = '{default: '0};
    logic [OW-1:0] expQ [$];
    logic [1:0][DW-1:0] userSamplePar2 = '0;
    logic userReady2;
    logic [0:0] userChannel2;
    logic [OW-1:0] resSample2;
    logic [0:0] resChannel2;
    logic resValid2;
    logic signed [DW-1:0] histPar [2][TAPS] = '{default: '0};
    logic [1:0][DW-1:0] parModel = '0;
    logic [OW:0] expQ2 [$];
    logic [OW:0] exp2;
    int chModel = 0;
    logic vinModel = 1'h0;
    fir_link_if #(.NUM_TAPS(TAPS), .DATA_W(DW), .COEF_W(CW), .NUM_CH(1)) link ();
    da_fir_filter #(.NUM_TAPS(TAPS), .DATA_W(DW), .COEF_W(CW), .COEF_FRAC(7), .NUM_CH(1)) da_fir_filter_i (
        .sys_clk(sys_clk), .rst(rst), .link(link));
    fir_source #(.NUM_TAPS(TAPS), .DATA_W(DW), .COEF_W(CW), .NUM_CH(1)) fir_source_i (
        .sys_clk(sys_clk), .rst(rst), .link(link), .userSample(userSample), .userSamplePar(userSamplePar),
        .userValid(userValid), .userLoadReq(userLoadReq), .userCoef(userCoef), .userCoefWe(userCoefWe),
        .userReady(userReady), .userChannel(userChannel), .resSample(resSample), .resChannel(resChannel),
        .resValid(resValid), .resReady(resReady));
    fir_link_if #(.NUM_TAPS(TAPS), .DATA_W(DW), .COEF_W(CW), .NUM_CH(2)) link2 ();
    // two parallel channels also ask for decimation, which a bank must refuse
    if (TAPS > 0) begin : bank2
        da_fir_filter #(.NUM_TAPS(TAPS), .DATA_W(DW), .COEF_W(CW), .COEF_FRAC(7), .NUM_CH(2), .SERIAL_IN(1'h0),
            .RATE(fir_pkg::RATE_DECIM), .TAP_STRUCT(fir_pkg::STRUCT_SYM)) da_fir_filter_i (
            .sys_clk(sys_clk), .rst(rst), .link(link2));
        fir_source #(.NUM_TAPS(TAPS), .DATA_W(DW), .COEF_W(CW), .NUM_CH(2),
            .RATE(fir_pkg::RATE_DECIM)) fir_source_i (
            .sys_clk(sys_clk), .rst(rst), .link(link2), .userSample(userSample), .userSamplePar(userSamplePar2),
            .userValid(userValid), .userLoadReq(userLoadReq), .userCoef(userCoef), .userCoefWe(userCoefWe),
            .userReady(userReady2), .userChannel(userChannel2), .resSample(resSample2), .resChannel(resChannel2),
            .resValid(resValid2), .resReady(resReady));
    end
    fir_link_properties #(.NUM_TAPS(TAPS), .DATA_W(DW), .COEF_W(CW), .NUM_CH(1)) fir_link_properties_i (
        .sys_clk(sys_clk), .rst(rst), .vin(link.vin), .rfd(link.rfd), .load(link.load), .coefWe(link.coefWe),
        .sampleOut(link.sampleOut), .vout(link.vout), .outReady(link.outReady), .selIn(link.selIn),
        .selOut(link.selOut));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsrNext
    function automatic logic [OW-1:0] firExpect();
        logic signed [OW-1:0] acc;
        acc = '0;
        for (int i = 0; i < TAPS; i++) begin
            acc = acc + coefModel[i] * histModel[i];
        end
        return acc;
    endfunction : firExpect
    // symmetric taps mirror the first half of the written words
    function automatic logic [OW-1:0] symExpect(input int ch);
        logic signed [OW-1:0] acc;
        acc = '0;
        for (int i = 0; i < TAPS; i++) begin
            acc = acc + coefModel[(i >= TAPS - TAPS / 2) ? TAPS - 1 - i : i] * histPar[ch][i];
        end
        return acc;
    endfunction : symExpect
    task automatic stopTest();
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stopTest
    task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : checkVal
    task automatic checkFlag(input string what, input logic exp, input logic got);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : checkFlag
    task automatic tick();
        @(posedge sys_clk);
        #5;
    endtask : tick
    // model follows the wire, so refused or invalid offers never enter it
    always @(posedge sys_clk) begin
        cycles++;
        if (!rst && link.rfd && link.vin) begin
            for (int i = TAPS - 1; i > 0; i--) begin
                histModel[i] = histModel[i-1];
            end
            histModel[0] = signed'(link.sampleIn);
            expQ.push_back(firExpect());
            checkVal("in channel", 0, userChannel);
        end
        if (!rst && resValid && resReady) begin
            checkFlag("result expected", 1'h1, expQ.size() != 0);
            if (expQ.size() != 0) begin
                checkVal("result", expQ.pop_front(), resSample);
            end
            checkVal("out channel", '0, resChannel);
        end
        if (!rst && link2.rfd) begin
            checkVal("in channel2", chModel, userChannel2);
            if (chModel == 0) begin
                parModel = link2.sampleInPar;
                vinModel = link2.vin;
            end else begin
                checkFlag("group valid", vinModel, link2.vin);
            end
            if (link2.vin) begin
                for (int i = TAPS - 1; i > 0; i--) begin
                    histPar[chModel][i] = histPar[chModel][i-1];
                end
                histPar[chModel][0] = signed'(parModel[chModel]);
                expQ2.push_back({chModel[0], symExpect(chModel)});
            end
            chModel = (chModel + 1) % 2;
        end
        if (!rst && resValid2 && resReady) begin
            checkFlag("result2 expected", 1'h1, expQ2.size() != 0);
            if (expQ2.size() != 0) begin
                exp2 = expQ2.pop_front();
                checkVal("result2", exp2[OW-1:0], resSample2);
                checkVal("out channel2", exp2[OW], resChannel2);
            end
        end
        if (cycles > 20000) begin
            errTotal++;
            stopTest();
        end
    end
    task automatic drain();
        int n;
        userValid = 1'h0;
        resReady = 1'h1;
        n = 0;
        while ((resValid || resValid2 || expQ.size() != 0 || expQ2.size() != 0) && n < 100) begin
            tick();
            n++;
        end
        checkVal("pending results", 0, expQ.size());
        checkVal("pending results2", 0, expQ2.size());
    endtask : drain
    task automatic reload(input int count, input bit spaced);
        int n;
        drain();
        userLoadReq = 1'h1;
        tick();
        userLoadReq = 1'h0;
        checkFlag("ready after load", 1'h0, userReady);
        checkFlag("ready2 after load", 1'h0, userReady2);
        n = 0;
        while (n < count) begin
            lfsrState = lfsrNext(lfsrState);
            userCoef = lfsrState[CW-1:0];
            // unwritten cycles still carry a changing word
            userCoefWe = !spaced || lfsrState[15];
            if (userCoefWe) begin
                coefModel[n] = userCoef;
                n++;
            end
            tick();
        end
        userCoefWe = 1'h0;
        if (count == TAPS) begin
            n = 0;
            while (!userReady && n < 40) begin
                tick();
                n++;
            end
            checkVal("rebuild cycles", TAPS + `FIR_REBUILD_BASE, n);
            while (!userReady2 && n < 40) begin
                tick();
                n++;
            end
            checkVal("rebuild cycles2", TAPS + TAPS / 2 + `FIR_REBUILD_BASE, n);
        end
        $display("reload of %0d words done", count);
    endtask : reload
    task automatic stream(input int count, input bit zero);
        int n;
        for (int i = 0; i < count; i++) begin
            lfsrState = lfsrNext(lfsrState);
            userSample = zero ? '0 : lfsrState[DW-1:0];
            userSamplePar2 = zero ? '0 : {lfsrState[7:0], lfsrState[15:8]};
            userValid = zero | lfsrState[8] | lfsrState[11];
            resReady = lfsrState[9] | lfsrState[12];
            n = 0;
            while (!userReady && n < 50) begin
                resReady = 1'h1;
                tick();
                n++;
            end
            tick();
        end
        $display("stream of %0d samples done", count);
    endtask : stream
    task automatic fill();
        int n;
        drain();
        resReady = 1'h0;
        userValid = 1'h1;
        n = 0;
        while (userReady && n < 40) begin
            lfsrState = lfsrNext(lfsrState);
            userSample = lfsrState[DW-1:0];
            tick();
            n++;
        end
        checkVal("buffer depth", `FIR_FIFO_DEPTH, n);
        drain();
        $display("fill and drain done");
    endtask : fill
    initial begin
        repeat (8) @(posedge sys_clk);
        #5;
        rst = 1'h0;
        checkFlag("ready at start", 1'h1, userReady);
        checkFlag("ready2 at start", 1'h1, userReady2);
        reload(TAPS, 1'h0);
        stream(60, 1'h0);
        fill();
        stream(TAPS, 1'h1);
        reload(TAPS, 1'h1);
        stream(60, 1'h0);
        stream(TAPS, 1'h1);
        reload(2, 1'h0);
        reload(TAPS, 1'h0);
        stream(60, 1'h0);
        drain();
        stopTest();
    end
endmodule : da_fir_filter_reload_test

// ===== fir_fifo.sv
`timescale 1ns/1ps
`include "fir_regs.svh"
module fir_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `FIR_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_st_t;
    fifo_st_t st, next_st;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        next_st = st;
        inReady = (st.count != (AW+1)'(DEPTH));
        outValid = (st.count != '0);
        outData = st.mem[st.rd];
        push = inValid && inReady;
        pop = outValid && outReady;
        if (push) begin
            next_st.mem[st.wr] = inData;
            next_st.wr = bump(st.wr);
        end
        if (pop) begin
            next_st.rd = bump(st.rd);
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : fir_fifo

// ===== fir_link_if.sv
`timescale 1ns/1ps
`include "fir_regs.svh"
interface fir_link_if #(
    parameter int NUM_TAPS = `FIR_DEF_TAPS,
    parameter int DATA_W = `FIR_DEF_DATA_W,
    parameter int COEF_W = `FIR_DEF_COEF_W,
    parameter int NUM_CH = 1
);
    localparam int OUT_W = DATA_W + COEF_W + $clog2(NUM_TAPS);
    localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
    logic [DATA_W-1:0] sampleIn;
    logic [NUM_CH-1:0][DATA_W-1:0] sampleInPar;
    logic vin;
    logic rfd;
    logic load;
    logic [COEF_W-1:0] coef;
    logic coefWe;
    logic [OUT_W-1:0] sampleOut;
    logic vout;
    logic outReady;
    logic [CH_W-1:0] selIn;
    logic [CH_W-1:0] selOut;
    modport device (input sampleIn, sampleInPar, vin, load, coef, coefWe, outReady,
        output rfd, sampleOut, vout, selIn, selOut);
    modport source (output sampleIn, sampleInPar, vin, load, coef, coefWe, outReady,
        input rfd, sampleOut, vout, selIn, selOut);
endinterface : fir_link_if

// ===== fir_link_properties.sv
`timescale 1ns/1ps
module fir_link_properties #(
    parameter int NUM_TAPS = 4,
    parameter int DATA_W = 8,
    parameter int COEF_W = 8,
    parameter int NUM_CH = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic vin,
    input wire logic rfd,
    input wire logic load,
    input wire logic coefWe,
    input wire logic [DATA_W+COEF_W+$clog2(NUM_TAPS)-1:0] sampleOut,
    input wire logic vout,
    input wire logic outReady,
    input wire logic [((NUM_CH > 1) ? $clog2(NUM_CH) : 1)-1:0] selIn,
    input wire logic [((NUM_CH > 1) ? $clog2(NUM_CH) : 1)-1:0] selOut
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // counts fixed for four unfolded taps: rebuild is taps plus four
    sequence fullLoad;
        load ##1 (coefWe && !load)[*4];
    endsequence
    sequence rebuildWait;
        (!rfd)[*8] ##1 rfd;
    endsequence
    AST_RFD_AT_START: assert property ($fell(rst) |-> rfd) else $error("ready low after reset");
    AST_RFD_DROP: assert property (load |=> !rfd) else $error("ready high after load");
    AST_RELOAD_LOW: assert property (load |=> (!rfd)[*8]) else $error("ready back too soon");
    AST_RELOAD_TIME: assert property (fullLoad |-> ##1 rebuildWait) else $error("rebuild timing wrong");
    AST_VOUT_HOLD: assert property (vout && !outReady |=> vout && $stable(sampleOut)) else $error("result lost");
    AST_SELOUT_HOLD: assert property (vout && !outReady |=> $stable(selOut)) else $error("channel changed");
    AST_SEL_CHANNEL: assert property (selIn == '0 && (!vout || selOut == '0)) else $error("bad channel");
    AST_VOUT_AFTER_TAKE: assert property (rfd && vin && !vout && !load |=> vout) else $error("no result");
    AST_NO_TAKE: assert property ((!rfd || !vin) && !vout |=> !vout) else $error("spurious result");
endmodule : fir_link_properties

// ===== fir_pkg.sv
package fir_pkg;
    typedef enum logic [1:0] {RATE_DECIM, RATE_INTERP, RATE_SINGLE} rate_mode_t;
    typedef enum logic [2:0] {STRUCT_INFERRED, STRUCT_NONE, STRUCT_SYM, STRUCT_NEGSYM, STRUCT_HALFBAND,
        STRUCT_INTERP} tap_struct_t;
    typedef enum logic [1:0] {ST_RUN, ST_RELOAD, ST_REBUILD} reload_state_t;
endpackage : fir_pkg

// ===== fir_regs.svh
`ifndef FIR_REGS_SVH
`define FIR_REGS_SVH
`define FIR_MAX_CH 8
`define FIR_DEF_TAPS 8
`define FIR_DEF_DATA_W 16
`define FIR_DEF_COEF_W 16
`define FIR_DEF_COEF_FRAC 15
`define FIR_DEF_FACTOR 2
`define FIR_FIFO_DEPTH 16
`define FIR_REBUILD_BASE 4
`define FIR_RESET_PHASE 0
`endif

// ===== fir_source.sv
`timescale 1ns/1ps
`include "fir_regs.svh"
module fir_source #(
    parameter int NUM_TAPS = `FIR_DEF_TAPS,
    parameter int DATA_W = `FIR_DEF_DATA_W,
    parameter int COEF_W = `FIR_DEF_COEF_W,
    parameter int NUM_CH = 1,
    parameter fir_pkg::rate_mode_t RATE = fir_pkg::RATE_SINGLE,
    parameter int FACTOR = `FIR_DEF_FACTOR
) (
    input wire logic sys_clk,
    input wire logic rst,
    fir_link_if.source link,
    input wire logic [DATA_W-1:0] userSample,
    input wire logic [NUM_CH-1:0][DATA_W-1:0] userSamplePar,
    input wire logic userValid,
    input wire logic userLoadReq,
    input wire logic [COEF_W-1:0] userCoef,
    input wire logic userCoefWe,
    output logic userReady,
    output logic [((NUM_CH > 1) ? $clog2(NUM_CH) : 1)-1:0] userChannel,
    output logic [DATA_W+COEF_W+$clog2(NUM_TAPS)-1:0] resSample,
    output logic [((NUM_CH > 1) ? $clog2(NUM_CH) : 1)-1:0] resChannel,
    output logic resValid,
    input wire logic resReady
);
    localparam int GROUP = (NUM_CH > 1) ? NUM_CH : ((RATE == fir_pkg::RATE_DECIM) ? FACTOR : 1);
    localparam int G_W = (GROUP > 1) ? $clog2(GROUP) : 1;

    typedef struct packed {
        logic prevLoad;
        logic heldValid;
        logic [G_W-1:0] groupCnt;
    } src_st_t;
    src_st_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.prevLoad = userLoadReq;
        // a long request still gives the filter a single pulse
        link.load = userLoadReq && !st.prevLoad;
        link.sampleIn = userSample;
        link.sampleInPar = userSamplePar;
        link.vin = (st.groupCnt == '0) ? userValid : st.heldValid;
        link.coef = userCoef;
        link.coefWe = userCoefWe;
        link.outReady = resReady;
        userReady = link.rfd;
        userChannel = link.selIn;
        resSample = link.sampleOut;
        resChannel = link.selOut;
        resValid = link.vout;
        if (link.rfd && GROUP > 1) begin
            if (st.groupCnt == '0) begin
                next_st.heldValid = userValid;
            end
            next_st.groupCnt = (st.groupCnt == G_W'(GROUP - 1)) ? '0 : st.groupCnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : fir_source
